// ===== hdl/crs_device.sv
// crs_device: character row refresh sequencer with cursor and glyph pipeline
// assumes ram_data and glyph_bits come from memories on the same clock
//
// Overview of operation
// - each scan line of a row replays its 80 addresses
// - sequential rows start 050H apart, 000H..EB0H
// - any row may start at any loaded address
// - lines 7..9 blank, address outputs released
// - entering scan line 8 of rows 0..23 raises new-row interrupt
// - processor loads next start, clears within 64us
// - loaded start used on all following-row lines
// - ram released when not refreshing, except from char 90 of line 9; processor uses it
// - address port drives refresh and loads registers
// - cursor delayed to match memory access times
// - glyph address latched, glyph shifted out as video
// - power-up reset; cursor and top set to 000H
// - frame refreshes 1920 characters from top of page
// - processor clears latches before enabling interrupts
// - hold last-plus-one, load start three chars early
// - vertical blank raises the vertical interrupt
`timescale 1ns/10ps
`default_nettype none
module crs_device
  import crs_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  crs_link.dev                   link,
  input  wire logic [CODE_W-1:0] ram_data,
  input  wire logic [DOTS-1:0]   glyph_bits,
  output logic [CODE_W+3:0]      glyph_addr,
  output logic                   glyph_address_latch,
  output logic                   video_shifter_load,
  output logic                   video,
  output logic                   cursor,
  output logic                   vertical_blank,
  output logic                   line_rate_pulse,
  output logic                   line_counter_clear,
  output logic [3:0]             scan_line_count
);
  logic [1:0]        div_cnt;
  logic [2:0]        dot_cnt;
  logic [6:0]        char_cnt;
  logic [4:0]        row_cnt;
  logic [ADDR_W-1:0] addr_cnt;
  logic [ADDR_W-1:0] row_base;
  logic [ADDR_W-1:0] row_start_register;
  logic [ADDR_W-1:0] cursor_reg;
  logic [ADDR_W-1:0] top_reg;
  logic              addr_oe;
  logic              ram_free;
  logic              new_row_irq;
  logic              vert_irq;
  logic [CURSOR_STAGES-2:0] cur_pipe;
  logic              vis_q;
  logic [DOTS-1:0]   shifter;

  wire logic         dot_tick  = div_cnt == DIV_LAST;
  wire logic         char_tick = dot_tick && dot_cnt == DOT_LAST;
  wire logic         line_end  = char_tick && char_cnt == CHAR_LAST;
  wire logic         row_end   = line_end && scan_line_count == SCAN_LAST;
  wire logic         frame_end = row_end && row_cnt == ROW_LAST;
  wire logic         last_line = scan_line_count == SCAN_LAST;
  wire logic         active    = char_cnt < VIS_CHARS;
  wire logic         preload   = char_tick && char_cnt == PRELOAD_CHAR;

  logic [2:0] next_dot;
  logic [6:0] next_char;
  logic [3:0] next_scan;
  logic [4:0] next_row;
  assign next_dot  = !dot_tick ? dot_cnt : (dot_cnt == DOT_LAST ? '0 : 3'(dot_cnt + 3'h1));
  assign next_char = line_end ? '0 : (char_tick ? 7'(char_cnt + 7'h01) : char_cnt);
  assign next_scan = row_end ? '0 : (line_end ? 4'(scan_line_count + 4'h1) : scan_line_count);
  assign next_row  = frame_end ? '0 : (row_end ? 5'(row_cnt + 5'h01) : row_cnt);

  wire logic next_vblank = next_row >= VIS_ROWS;
  wire logic next_video  = !next_vblank && next_scan < FONT_LINES;
  wire logic next_guard  = next_scan == SCAN_LAST && next_char >= GUARD_CHAR;

  // row 0 of a frame starts at top of page, every other row at the loaded start
  wire logic [ADDR_W-1:0] row_src = (row_cnt == ROW_LAST) ? top_reg : row_start_register;

  wire logic row_irq_set  = line_end && scan_line_count == IRQ_PREV_LINE && row_cnt < VIS_ROWS;
  wire logic vert_irq_set = row_end && row_cnt == VIS_LAST_ROW;
  wire logic load_ok      = link.reg_load && !addr_oe;
  wire logic cur_hit      = addr_oe && active && addr_cnt == cursor_reg;

  assign link.dev_addr    = addr_cnt;
  assign link.dev_addr_oe = addr_oe;
  assign link.ram_free    = ram_free;
  assign link.new_row_irq = new_row_irq;
  assign link.vert_irq    = vert_irq;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_cnt         <= '0;
      dot_cnt         <= '0;
      char_cnt        <= '0;
      scan_line_count <= '0;
      row_cnt         <= '0;
    end else begin
      div_cnt         <= 2'(div_cnt + 2'h1);
      dot_cnt         <= next_dot;
      char_cnt        <= next_char;
      scan_line_count <= next_scan;
      row_cnt         <= next_row;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_oe            <= 1'b0;
      ram_free           <= 1'b0;
      vertical_blank     <= 1'b0;
      line_rate_pulse    <= 1'b0;
      line_counter_clear <= 1'b0;
    end else begin
      addr_oe            <= next_video;
      ram_free           <= !next_video && !next_guard;
      vertical_blank     <= next_vblank;
      line_rate_pulse    <= line_end;
      line_counter_clear <= row_end;
    end
  end

  // refresh address counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_cnt <= HOME_ADDR;
      row_base <= HOME_ADDR;
    end else if (preload) begin
      if (last_line) begin
        row_base <= row_src;
        addr_cnt <= row_src;
      end else begin
        addr_cnt <= row_base;
      end
    end else if (char_tick && active) begin
      addr_cnt <= 12'(addr_cnt + 12'h001);
    end
  end

  // registers loaded through the address port while it is released
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      row_start_register <= HOME_ADDR;
      cursor_reg         <= HOME_ADDR;
      top_reg            <= HOME_ADDR;
    end else if (load_ok) begin
      case (link.reg_sel)
        CRS_SEL_ROW:    row_start_register <= link.addr_bus;
        CRS_SEL_CURSOR: cursor_reg         <= link.addr_bus;
        CRS_SEL_TOP:    top_reg            <= link.addr_bus;
        default:        ;
      endcase
    end
  end

  // a set in the clearing cycle wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      new_row_irq <= 1'b0;
      vert_irq    <= 1'b0;
    end else begin
      new_row_irq <= row_irq_set | (new_row_irq & ~link.irq_clear);
      vert_irq    <= vert_irq_set | (vert_irq & ~link.irq_clear);
    end
  end

  // glyph path and cursor alignment, both advanced per character time
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      glyph_addr          <= '0;
      glyph_address_latch <= 1'b0;
      video_shifter_load  <= 1'b0;
      vis_q               <= 1'b0;
      shifter             <= '0;
      video               <= 1'b0;
      cur_pipe            <= '0;
      cursor              <= 1'b0;
    end else begin
      glyph_address_latch <= char_tick;
      video_shifter_load  <= char_tick;
      if (char_tick) begin
        glyph_addr <= {ram_data, scan_line_count};
        vis_q      <= addr_oe && active;
        shifter    <= vis_q ? glyph_bits : '0;
        cur_pipe   <= {cur_pipe[CURSOR_STAGES-3:0], cur_hit};
        cursor     <= cur_pipe[CURSOR_STAGES-2];
      end else if (dot_tick) begin
        shifter <= {shifter[DOTS-2:0], 1'b0};
      end
      if (dot_tick) begin
        video <= shifter[DOTS-1];
      end
    end
  end
endmodule
`default_nettype wire

// ===== hdl/crs_host.sv
// crs_host: controller end; serves row and vertical interrupts of the sequencer
// assumes an AXI4-Lite master on the same clock; registers are one word each
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module crs_host
  import crs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  crs_link.host            link,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);
  function automatic logic [11:0] merge(input logic [11:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    merge = {s[1] ? d[11:8] : old[11:8], s[0] ? d[7:0] : old[7:0]};
  endfunction
  function automatic logic [11:0] wrap_add(input logic [11:0] a);
    logic [11:0] sum;
    sum      = 12'(a + ROW_STRIDE);
    wrap_add = (sum >= ADDR_WRAP) ? HOME_ADDR : sum;
  endfunction

  logic [4:0]  aw_q;
  logic [31:0] wd_q;
  logic [3:0]  ws_q;
  logic [1:0]  ctrl_r;
  logic [11:0] next_row_r;
  logic [11:0] cursor_r;
  logic [11:0] top_r;
  logic [2:0]  status;
  logic [2:0]  mask;
  logic [11:0] seq_ptr;
  logic [3:0]  pend;
  logic        init_done;
  logic        row_q;
  logic        vert_q;
  logic        late_run;
  logic [11:0] late_cnt;
  crs_hstate_t hstate;
  crs_sel_t    job;

  wire logic row_ev  = link.new_row_irq & ~row_q;
  wire logic vert_ev = link.vert_irq & ~vert_q;
  wire logic serve   = init_done && ctrl_r[CTRL_SERVE];
  wire logic wr_do   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic wr_hit  = aw_q <= OFS_MASK && aw_q[1:0] == 2'h0;
  wire logic rd_hit  = s_axi_araddr <= OFS_LIVE && s_axi_araddr[1:0] == 2'h0;
  wire logic [2:0] w1c = (wr_do && aw_q == OFS_STATUS && ws_q[0]) ? wd_q[2:0] : 3'h0;
  wire logic late_hit = late_run && late_cnt == LATE_LAST;
  wire logic drive_go = hstate == CRS_HS_IDLE && link.ram_free && |pend;
  wire logic job_done = hstate == CRS_HS_DRIVE;
  wire logic [3:0] done_mask = job_done ? (4'h1 << job) : 4'h0;
  wire crs_sel_t pick = pend[CRS_SEL_CURSOR] ? CRS_SEL_CURSOR :
                        pend[CRS_SEL_TOP]    ? CRS_SEL_TOP    :
                        pend[CRS_SEL_ROW]    ? CRS_SEL_ROW    : CRS_SEL_CLEAR;
  wire logic [11:0] row_val = ctrl_r[CTRL_SEQ] ? seq_ptr : next_row_r;
  wire logic [11:0] pick_val = pick == CRS_SEL_CURSOR ? cursor_r :
                               pick == CRS_SEL_TOP    ? top_r : row_val;
  // one bit per job, indexed by its select code: clear, top, cursor, row
  wire logic [3:0] set_mask = {serve && (row_ev || vert_ev), wr_do && aw_q == OFS_TOP,
    wr_do && aw_q == OFS_CURSOR, serve && row_ev};
  wire logic [31:0] rd_word =
    s_axi_araddr == OFS_CTRL     ? {30'h0, ctrl_r} :
    s_axi_araddr == OFS_NEXT_ROW ? {20'h0, next_row_r} :
    s_axi_araddr == OFS_CURSOR   ? {20'h0, cursor_r} :
    s_axi_araddr == OFS_TOP      ? {20'h0, top_r} :
    s_axi_araddr == OFS_STATUS   ? {29'h0, status} :
    s_axi_araddr == OFS_MASK     ? {29'h0, mask} :
    s_axi_araddr == OFS_LIVE     ? {30'h0, init_done, link.ram_free} : 32'h0;

  // axi4-lite slave
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
      aw_q          <= 5'h00;
      wd_q          <= 32'h0;
      ws_q          <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q          <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd_q         <= s_axi_wdata;
        ws_q         <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r     <= 2'h0;
      next_row_r <= HOME_ADDR;
      cursor_r   <= HOME_ADDR;
      top_r      <= HOME_ADDR;
      mask       <= 3'h0;
    end else if (wr_do) begin
      case (aw_q)
        OFS_CTRL:     ctrl_r     <= ws_q[0] ? wd_q[1:0] : ctrl_r;
        OFS_NEXT_ROW: next_row_r <= merge(next_row_r, wd_q, ws_q);
        OFS_CURSOR:   cursor_r   <= merge(cursor_r, wd_q, ws_q);
        OFS_TOP:      top_r      <= merge(top_r, wd_q, ws_q);
        OFS_MASK:     mask       <= ws_q[0] ? wd_q[2:0] : mask;
        default:      ;
      endcase
    end
  end

  // events, sticky status and the lateness watchdog
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      row_q    <= 1'b0;
      vert_q   <= 1'b0;
      status   <= 3'h0;
      irq      <= 1'b0;
      late_run <= 1'b0;
      late_cnt <= 12'h000;
    end else begin
      row_q  <= link.new_row_irq;
      vert_q <= link.vert_irq;
      status <= {late_hit, vert_ev, row_ev} | (status & ~w1c);
      irq    <= |(status & mask);
      if (serve && row_ev) begin
        late_run <= 1'b1;
        late_cnt <= 12'h000;
      end else if (job_done && job == CRS_SEL_CLEAR || late_hit) begin
        late_run <= 1'b0;
      end else if (late_run) begin
        late_cnt <= 12'(late_cnt + 12'h001);
      end
    end
  end

  // one-cycle register loads and latch clears over the shared address port
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hstate            <= CRS_HS_IDLE;
      job               <= CRS_SEL_CLEAR;
      pend              <= 4'b1110;
      init_done         <= 1'b0;
      seq_ptr           <= ROW_STRIDE;
      link.host_addr    <= HOME_ADDR;
      link.host_addr_oe <= 1'b0;
      link.reg_load     <= 1'b0;
      link.reg_sel      <= CRS_SEL_ROW;
      link.irq_clear    <= 1'b0;
    end else begin
      pend <= (pend & ~done_mask) | set_mask;
      if (serve && vert_ev) begin
        seq_ptr <= wrap_add(top_r);
      end else if (job_done && job == CRS_SEL_ROW) begin
        seq_ptr <= wrap_add(seq_ptr);
      end
      case (hstate)
        CRS_HS_IDLE: begin
          if (drive_go) begin
            hstate            <= CRS_HS_DRIVE;
            job               <= pick;
            link.host_addr    <= pick_val;
            link.host_addr_oe <= pick != CRS_SEL_CLEAR;
            link.reg_load     <= pick != CRS_SEL_CLEAR;
            link.reg_sel      <= pick;
            link.irq_clear    <= pick == CRS_SEL_CLEAR;
          end
        end
        CRS_HS_DRIVE: begin
          hstate            <= CRS_HS_IDLE;
          link.host_addr_oe <= 1'b0;
          link.reg_load     <= 1'b0;
          link.irq_clear    <= 1'b0;
          if (job == CRS_SEL_CLEAR) begin
            init_done <= 1'b1;
          end
        end
        default: hstate <= CRS_HS_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== hdl/crs_link.sv
// crs_link: shared address port, register loads and interrupt latches between the ends
// assumes both ends run on the same clock; the bus level is resolved here from the enables
`timescale 1ns/10ps
`default_nettype none
interface crs_link;
  import crs_pkg::*;
  logic [ADDR_W-1:0] dev_addr;
  logic              dev_addr_oe;
  logic [ADDR_W-1:0] host_addr;
  logic              host_addr_oe;
  logic [ADDR_W-1:0] addr_bus;
  logic              ram_free;
  logic              reg_load;
  crs_sel_t          reg_sel;
  logic              irq_clear;
  logic              new_row_irq;
  logic              vert_irq;
  // an undriven bus reads as zero
  assign addr_bus = dev_addr_oe ? dev_addr : (host_addr_oe ? host_addr : '0);
  modport dev (
    output dev_addr, dev_addr_oe, ram_free, new_row_irq, vert_irq,
    input  addr_bus, reg_load, reg_sel, irq_clear
  );
  modport host (
    output host_addr, host_addr_oe, reg_load, reg_sel, irq_clear,
    input  addr_bus, dev_addr_oe, ram_free, new_row_irq, vert_irq
  );
endinterface
`default_nettype wire

// ===== hdl/crs_pkg.sv
// crs_pkg: constants and types shared by the row refresh sequencer and its controller
// assumes a single 40 MHz clock shared by both ends
package crs_pkg;
  localparam int          ADDR_W        = 12;
  localparam int          CODE_W        = 7;
  localparam int          DOTS          = 7;
  localparam int          CURSOR_STAGES = 3;
  localparam logic [1:0]  DIV_LAST      = 2'h3;   // four clocks per dot
  localparam logic [2:0]  DOT_LAST      = 3'h6;   // seven dots per character
  localparam logic [6:0]  CHAR_LAST     = 7'h63;  // 100 character times per line
  localparam logic [6:0]  VIS_CHARS     = 7'h50;  // 80 characters of video
  localparam logic [6:0]  PRELOAD_CHAR  = 7'h60;  // three character times before video
  localparam logic [6:0]  GUARD_CHAR    = 7'h5a;  // ram handed back ahead of row start
  localparam logic [3:0]  SCAN_LAST     = 4'h9;   // ten scan lines per row
  localparam logic [3:0]  FONT_LINES    = 4'h7;   // lines 7..9 carry no video
  localparam logic [3:0]  IRQ_PREV_LINE = 4'h7;   // advancing past it enters line 8
  localparam logic [4:0]  VIS_ROWS      = 5'h18;  // 24 rows of video
  localparam logic [4:0]  VIS_LAST_ROW  = 5'h17;
  localparam logic [4:0]  ROW_LAST      = 5'h19;  // two blank rows of retrace
  localparam logic [11:0] ROW_STRIDE    = 12'h050;
  localparam logic [11:0] ADDR_WRAP     = 12'hf00;
  localparam logic [11:0] HOME_ADDR     = 12'h000;
  localparam int          CLK_NS        = 25;
  localparam int          ROW_SERVICE_NS  = 64000;
  localparam int          ROW_SERVICE_CYC = ROW_SERVICE_NS / CLK_NS;
  localparam logic [11:0] LATE_LAST     = 12'(ROW_SERVICE_CYC - 1);
  localparam logic [4:0]  OFS_CTRL      = 5'h00;
  localparam logic [4:0]  OFS_NEXT_ROW  = 5'h04;
  localparam logic [4:0]  OFS_CURSOR    = 5'h08;
  localparam logic [4:0]  OFS_TOP       = 5'h0c;
  localparam logic [4:0]  OFS_STATUS    = 5'h10;
  localparam logic [4:0]  OFS_MASK      = 5'h14;
  localparam logic [4:0]  OFS_LIVE      = 5'h18;
  localparam int          CTRL_SERVE    = 0;
  localparam int          CTRL_SEQ      = 1;
  localparam int          ST_ROW        = 0;
  localparam int          ST_VERT       = 1;
  localparam int          ST_LATE       = 2;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  typedef enum logic [1:0] {
    CRS_SEL_ROW    = 2'b00,
    CRS_SEL_CURSOR = 2'b01,
    CRS_SEL_TOP    = 2'b10,
    CRS_SEL_CLEAR  = 2'b11
  } crs_sel_t;
  typedef enum logic [0:0] {
    CRS_HS_IDLE  = 1'b0,
    CRS_HS_DRIVE = 1'b1
  } crs_hstate_t;
endpackage

// ===== verif/crs_link_props.sv
// crs_link_props: assertions on the shared address port and interrupt latches
// assumes one clock for both ends; tb instantiates it beside the link
`timescale 1ns/10ps
`default_nettype none
module crs_link_props
  import crs_pkg::*;
(
  input wire logic              clk,
  input wire logic              arst_n,
  input wire logic [ADDR_W-1:0] dev_addr,
  input wire logic              dev_addr_oe,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic              host_addr_oe,
  input wire logic [ADDR_W-1:0] addr_bus,
  input wire logic              ram_free,
  input wire logic              reg_load,
  input wire logic              irq_clear,
  input wire logic              new_row_irq,
  input wire logic              vert_irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  a_port_one_driver: assert property (!(dev_addr_oe && host_addr_oe))
    else $error("port driven by both ends");
  a_host_when_free: assert property (host_addr_oe |-> ram_free)
    else $error("host drove port while ram busy");
  a_refresh_holds_ram: assert property (dev_addr_oe |-> !ram_free)
    else $error("ram free during refresh");
  a_load_from_host: assert property (reg_load |-> host_addr_oe && addr_bus == host_addr)
    else $error("load without host address");
  a_load_spaced: assert property (reg_load |=> !reg_load && !irq_clear)
    else $error("jobs not spaced");
  a_row_irq_held: assert property (new_row_irq && !irq_clear |=> new_row_irq)
    else $error("row latch dropped");
  a_vert_irq_held: assert property (vert_irq && !irq_clear |=> vert_irq)
    else $error("vertical latch dropped");
  a_row_irq_blank: assert property ($rose(new_row_irq) |-> !dev_addr_oe && ram_free)
    else $error("row irq on a video line");
  a_clear_drops: assert property (irq_clear |=> !new_row_irq && !vert_irq)
    else $error("latch not cleared");
  a_addr_step: assert property (dev_addr_oe && $past(dev_addr_oe) && $changed(dev_addr)
    |-> dev_addr == $past(dev_addr) + 12'h001 || $past(dev_addr) == dev_addr + ROW_STRIDE)
    else $error("refresh address jumped");
  c_row_irq: cover property ($rose(new_row_irq));
  c_load: cover property (reg_load);
  c_clear: cover property (irq_clear && new_row_irq);
endmodule
`default_nettype wire

// ===== verif/tb.sv
// tb: both ends joined by the link, host driven over AXI4-Lite
// assumes rows 0..3 are reached within the cycle ceiling
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb;
  import crs_pkg::*;
  logic        clk = 0;
  logic        arst_n = 0;
  logic [4:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, irq, lrp, cur, oe_q = 0;
  logic [1:0]  bresp, rresp, r;
  logic [6:0]  ram_data = '0, glyph_bits = '0;
  logic [10:0] glyph_addr;
  logic [11:0] starts[$];
  int          err_total = 0, n_compared = 0, cyc = 0, ncur = 0;
  always #12.5 clk = ~clk;
  crs_link i_crs_link ();
  crs_device i_crs_device (.clk(clk), .arst_n(arst_n), .link(i_crs_link),
    .ram_data(ram_data), .glyph_bits(glyph_bits), .glyph_addr(glyph_addr),
    .glyph_address_latch(), .video_shifter_load(), .video(), .cursor(cur),
    .vertical_blank(), .line_rate_pulse(lrp), .line_counter_clear(), .scan_line_count());
  crs_host i_crs_host (.clk(clk), .arst_n(arst_n), .link(i_crs_link), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
  crs_link_props i_crs_link_props (.clk(clk), .arst_n(arst_n),
    .dev_addr(i_crs_link.dev_addr), .dev_addr_oe(i_crs_link.dev_addr_oe),
    .host_addr(i_crs_link.host_addr), .host_addr_oe(i_crs_link.host_addr_oe),
    .addr_bus(i_crs_link.addr_bus), .ram_free(i_crs_link.ram_free),
    .reg_load(i_crs_link.reg_load), .irq_clear(i_crs_link.irq_clear),
    .new_row_irq(i_crs_link.new_row_irq), .vert_irq(i_crs_link.vert_irq));
  task automatic results();
    $display("counts compared=%0d bad=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // memories answer on the same clock; a rise of the refresh enable marks a new row,
  // every later line of that row must restart at the same address
  always @(posedge clk) begin
    ram_data <= i_crs_link.dev_addr[6:0];
    glyph_bits <= glyph_addr[6:0];
    oe_q <= i_crs_link.dev_addr_oe;
    cyc++;
    ncur += cur;
    if (i_crs_link.dev_addr_oe && !oe_q) begin
      starts.push_back(i_crs_link.dev_addr);
    end else if (i_crs_link.dev_addr_oe && lrp) begin
      `CHK(i_crs_link.dev_addr, starts[$])
    end
    if (cyc == 90000) begin
      err_total++;
      results();
    end
  end
  task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] e);
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end while (!bvalid);
    bready <= 0;
    `CHK(bresp, e)
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do @(posedge clk); while (!arready);
    arvalid <= 0;
    do @(posedge clk); while (!rvalid);
    rready <= 0;
    v = rdata;
    r = rresp;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1;
    rd(5'h1c, d);
    `CHK({r, d}, {RESP_SLVERR, 32'h0})
    wr(5'h1c, 32'h1, RESP_SLVERR);
    do rd(OFS_LIVE, d); while (d[1] !== 1'b1);
    rd(OFS_CURSOR, d);
    `CHK(d[11:0], HOME_ADDR)
    $display("test init done");
    wr(OFS_MASK, 32'h1, RESP_OKAY);
    wr(OFS_CTRL, 32'h3, RESP_OKAY);
    wait (irq === 1'b1);
    rd(OFS_STATUS, d);
    `CHK(d[2:0], 3'h1)
    wr(OFS_MASK, 32'h0, RESP_OKAY);
    @(posedge clk);
    `CHK(irq, 1'b0)
    wr(OFS_MASK, 32'h1, RESP_OKAY);
    @(posedge clk);
    `CHK(irq, 1'b1)
    wr(OFS_STATUS, 32'h1, RESP_OKAY);
    rd(OFS_STATUS, d);
    `CHK({d[2:0], irq}, 4'h0)
    wait (!i_crs_link.new_row_irq);
    wr(OFS_NEXT_ROW, 32'h0a0, RESP_OKAY);
    wr(OFS_CTRL, 32'h1, RESP_OKAY);
    $display("test interrupt done");
    wait (irq === 1'b1);
    wr(OFS_STATUS, 32'h1, RESP_OKAY);
    wait (!i_crs_link.new_row_irq);
    wr(OFS_CTRL, 32'h0, RESP_OKAY);
    while (starts.size() < 4) @(posedge clk);
    `CHK(starts[0], HOME_ADDR)
    `CHK(starts[1], HOME_ADDR + ROW_STRIDE)
    `CHK(starts[2], 12'h0a0)
    `CHK(starts[3], 12'h0a0)
    `CHK(ncur, 196)
    $display("test row starts done");
    results();
  end
endmodule
`default_nettype wire
